// File: rtl/gpio_cell.sv
// Logic cell between core fabric and one general-purpose pad
`timescale 1ns/1ns
`include "gpio_cell_params.svh"
module gpio_cell
  import gpio_cell_pkg::*;
(
  // Clocks and reset
  input  wire logic       REF_CLK,
  input  wire logic       NRST,
  input  wire logic       CAPTURE_REGISTER_CLOCK,
  input  wire logic       DRIVE_REGISTER_CLOCK,
  // Configuration
  input  wire cell_mode_t MODE,
  input  wire cell_cfg_t  CFG,
  // Core side
  input  wire logic [1:0] CORE_OUT,
  input  wire logic       CORE_OE,
  output logic      [1:0] CORE_IN,
  output logic            ALT_IN,
  // Pad side
  input  wire logic       PAD_I,
  output logic            PAD_O,
  output logic            PAD_OE
);
  logic in_en;
  logic out_en;
  logic oe_path;
  logic in_pos_q;
  logic in_neg_q;
  logic in_neg_rs_q;
  logic in_sel;
  logic [1:0] out_pre;
  logic out_pos_q;
  logic out_neg_q;
  logic out_rs_q;
  logic out_sel;
  logic oe_q;

  // ****************************************
  // Path enables per mode
  // ****************************************
  assign in_en   = (MODE == MODE_IN) || (MODE == MODE_BI);
  assign out_en  = (MODE == MODE_OUT) || (MODE == MODE_BI);
  assign oe_path = (MODE == MODE_BI);

  // ****************************************
  // Receive path
  // ****************************************
  // Double-edge samples on the capture clock
  always_ff @(posedge CAPTURE_REGISTER_CLOCK or negedge NRST) begin
    if (!NRST) begin
      in_pos_q <= `RST_LEVEL;
    end else begin
      in_pos_q <= PAD_I;
    end
  end

  always_ff @(negedge CAPTURE_REGISTER_CLOCK or negedge NRST) begin
    if (!NRST) begin
      in_neg_q <= `RST_LEVEL;
    end else begin
      in_neg_q <= PAD_I;
    end
  end

  // Falling sample held to the next rising edge
  always_ff @(posedge CAPTURE_REGISTER_CLOCK or negedge NRST) begin
    if (!NRST) begin
      in_neg_rs_q <= `RST_LEVEL;
    end else begin
      in_neg_rs_q <= in_neg_q;
    end
  end

  edge_flop u_in_flop (
    .clk (CAPTURE_REGISTER_CLOCK),
    .nrst(NRST),
    .neg (CFG.in_neg),
    .d   (PAD_I),
    .q   (in_sel)
  );

  // Core input picks the double-edge pair, the registered sample or the raw pad; zero unless input is enabled
  always_comb begin
    CORE_IN = 2'b00;
    if (in_en) begin
      if (CFG.in_ddr) begin
        CORE_IN = {(CFG.in_resync ? in_neg_rs_q : in_neg_q), in_pos_q};
      end else if (CFG.in_reg) begin
        CORE_IN = {1'b0, in_sel};
      end else begin
        CORE_IN = {1'b0, PAD_I};
      end
    end
  end

  // Unregistered alternate feed to other blocks
  assign ALT_IN = (in_en && CFG.alt_sel) ? PAD_I : 1'b0;

  // ****************************************
  // Drive path
  // ****************************************
  assign out_pre = CFG.out_inv ? ~CORE_OUT : CORE_OUT;

  // Bit 0 on rising edge, bit 1 on falling edge
  always_ff @(posedge DRIVE_REGISTER_CLOCK or negedge NRST) begin
    if (!NRST) begin
      out_pos_q <= `RST_LEVEL;
      out_rs_q  <= `RST_LEVEL;
    end else begin
      out_pos_q <= out_pre[0];
      out_rs_q  <= out_pre[1];
    end
  end

  always_ff @(negedge DRIVE_REGISTER_CLOCK or negedge NRST) begin
    if (!NRST) begin
      out_neg_q <= `RST_LEVEL;
    end else begin
      out_neg_q <= CFG.out_resync ? out_rs_q : out_pre[1];
    end
  end

  edge_flop u_out_flop (
    .clk (DRIVE_REGISTER_CLOCK),
    .nrst(NRST),
    .neg (CFG.out_neg),
    .d   (out_pre[0]),
    .q   (out_sel)
  );

  // Enable register on the drive clock
  edge_flop u_oe_flop (
    .clk (DRIVE_REGISTER_CLOCK),
    .nrst(NRST),
    .neg (CFG.oe_neg),
    .d   (CORE_OE),
    .q   (oe_q)
  );

  // ****************************************
  // Pad mux
  // ****************************************
  // Pad is a combinational mux of pad-clock registers, bypass core data and REF_CLK; retiming it onto
  // REF_CLK would break double-edge timing
  always_comb begin
    PAD_O  = 1'b0;
    PAD_OE = 1'b0;
    if (MODE == MODE_CK) begin
      PAD_O  = REF_CLK;
      PAD_OE = 1'b1;
    end else if (out_en) begin
      if (CFG.out_ddr) begin
        PAD_O = DRIVE_REGISTER_CLOCK ? out_pos_q : out_neg_q;
      end else if (CFG.out_reg) begin
        PAD_O = out_sel;
      end else begin
        PAD_O = CORE_OUT[0] ^ CFG.out_inv;
      end
      if (oe_path) begin
        PAD_OE = CFG.oe_reg ? oe_q : CORE_OE;
      end else begin
        PAD_OE = 1'b1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_input_no_drive: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_IN) |-> !PAD_OE) else $error("input mode drives pad");
  a_alt_follows_pad: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_IN && CFG.alt_sel) |-> (ALT_IN == PAD_I)) else $error("alt not raw pad");
  a_alt_off_output: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_OUT) |-> !ALT_IN) else $error("alt active in output mode");
  a_output_no_recv: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_OUT) |-> (CORE_IN == 2'b00)) else $error("output mode receives");
  a_bypass_invert: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_OUT && !CFG.out_reg && !CFG.out_ddr)
      |-> (PAD_O == (CORE_OUT[0] ^ CFG.out_inv))) else $error("bypass output wrong");
  a_clock_out_drive: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_CK) |-> PAD_OE) else $error("clock output not driven");
  a_bidir_oe_bypass: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (MODE == MODE_BI && !CFG.oe_reg) |-> (PAD_OE == CORE_OE)) else $error("oe bypass wrong");
  a_bypass_input: assert property (@(posedge REF_CLK) disable iff (!NRST)
    (in_en && !CFG.in_reg && !CFG.in_ddr) |-> (CORE_IN[0] == PAD_I))
    else $error("bypass input wrong");

  // Registered paths: what one active edge takes is seen at the next one
  sequence s_in_reg_rise;
    in_en && CFG.in_reg && !CFG.in_ddr && !CFG.in_neg;
  endsequence

  sequence s_in_reg_fall;
    in_en && CFG.in_reg && !CFG.in_ddr && CFG.in_neg;
  endsequence

  sequence s_in_ddr;
    in_en && CFG.in_ddr;
  endsequence

  sequence s_out_reg_rise;
    out_en && CFG.out_reg && !CFG.out_ddr && !CFG.out_neg;
  endsequence

  sequence s_out_reg_fall;
    out_en && CFG.out_reg && !CFG.out_ddr && CFG.out_neg;
  endsequence

  sequence s_oe_reg_rise;
    oe_path && CFG.oe_reg && !CFG.oe_neg;
  endsequence

  sequence s_oe_reg_fall;
    oe_path && CFG.oe_reg && CFG.oe_neg;
  endsequence

  a_in_reg_rise: assert property (@(posedge CAPTURE_REGISTER_CLOCK)
    disable iff (!NRST) s_in_reg_rise |=> (CORE_IN[0] == $past(PAD_I)))
    else $error("rising input capture wrong");
  a_in_reg_fall: assert property (@(negedge CAPTURE_REGISTER_CLOCK)
    disable iff (!NRST) s_in_reg_fall |=> (CORE_IN[0] == $past(PAD_I)))
    else $error("falling input capture wrong");
  a_ddr_in_rise: assert property (@(posedge CAPTURE_REGISTER_CLOCK)
    disable iff (!NRST) s_in_ddr |=> (CORE_IN[0] == $past(PAD_I)))
    else $error("double-edge rising sample wrong");
  a_ddr_in_fall: assert property (@(negedge CAPTURE_REGISTER_CLOCK)
    disable iff (!NRST) s_in_ddr |=> (CORE_IN[1] == $past(PAD_I)))
    else $error("double-edge falling sample wrong");
  a_out_reg_rise: assert property (@(posedge DRIVE_REGISTER_CLOCK)
    disable iff (!NRST) s_out_reg_rise |=> (PAD_O == ($past(CORE_OUT[0]) ^ CFG.out_inv)))
    else $error("rising output register wrong");
  a_out_reg_fall: assert property (@(negedge DRIVE_REGISTER_CLOCK)
    disable iff (!NRST) s_out_reg_fall |=> (PAD_O == ($past(CORE_OUT[0]) ^ CFG.out_inv)))
    else $error("falling output register wrong");
  a_oe_reg_rise: assert property (@(posedge DRIVE_REGISTER_CLOCK)
    disable iff (!NRST) s_oe_reg_rise |=> (PAD_OE == $past(CORE_OE)))
    else $error("rising enable register wrong");
  a_oe_reg_fall: assert property (@(negedge DRIVE_REGISTER_CLOCK)
    disable iff (!NRST) s_oe_reg_fall |=> (PAD_OE == $past(CORE_OE)))
    else $error("falling enable register wrong");
endmodule : gpio_cell

// File: rtl/gpio_cell_params.svh
// Constants for the general-purpose I/O logic cell
// Function
// - Input mode enables only the receive path, bypassed or registered on a selectable edge.
// - The alternate input path carries the pad value with no register stage.
// - The alternate input feeds another interface block directly, bypassing the core.
// - Double-edge input samples the pad on rising and falling edges into two streams.
// - Output mode enables only the drive path, bypassed or registered on a selectable edge.
// - The output register can drive the complement of the core data.
// - Double-edge output captures two bits on both edges and muxes them onto the pad.
// - Bidirectional mode enables input, output and enable paths, each with its own edge.
// - In bidirectional mode input and output paths choose register or bypass separately.
// - The output-enable register switches the pad driver on and off.
// - Input register captures the pad before the core; output register holds core data.
// - Clock-output mode drives the pad from the core clock tree, not from core data.
// - Double-edge bit 0 is the rising-edge sample or drive, bit 1 the falling-edge one.
// - Resync double-edge mode transfers both bits on the rising edge only.
// - In resync input mode the falling sample is delayed half a period to align.
`ifndef GPIO_CELL_PARAMS_SVH
`define GPIO_CELL_PARAMS_SVH

`define MODE_INPUT   4'h1
`define MODE_OUTPUT  4'h2
`define MODE_BIDIR   4'h4
`define MODE_CLKOUT  4'h8
`define RST_LEVEL    1'b0

`endif

// File: rtl/gpio_cell_pkg.sv
// Types for the general-purpose I/O logic cell
`include "gpio_cell_params.svh"
package gpio_cell_pkg;
  typedef enum logic [3:0] {
    MODE_IN  = `MODE_INPUT,
    MODE_OUT = `MODE_OUTPUT,
    MODE_BI  = `MODE_BIDIR,
    MODE_CK  = `MODE_CLKOUT
  } cell_mode_t;

  typedef struct packed {
    logic in_reg;
    logic in_neg;
    logic in_ddr;
    logic in_resync;
    logic out_reg;
    logic out_neg;
    logic out_inv;
    logic out_ddr;
    logic out_resync;
    logic oe_reg;
    logic oe_neg;
    logic alt_sel;
  } cell_cfg_t;
endpackage : gpio_cell_pkg

// File: rtl/edge_flop.sv
// Flip-flop on a selectable clock edge
`timescale 1ns/1ns
`include "gpio_cell_params.svh"
module edge_flop (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Edge choice and data
  input  wire logic neg,
  input  wire logic d,
  output logic      q
);
  logic pos_q;
  logic neg_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pos_q <= `RST_LEVEL;
    end else begin
      pos_q <= d;
    end
  end

  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      neg_q <= `RST_LEVEL;
    end else begin
      neg_q <= d;
    end
  end

  // Static configuration selects which edge stage is seen
  assign q = neg ? neg_q : pos_q;
endmodule : edge_flop

// File: verif/pad_model.sv
// Pad wire model standing on the far side of the I/O cell
`timescale 1ns/1ns
module pad_model (
  // Cell side
  input  wire logic pad_o,
  input  wire logic pad_oe,
  output logic      pad_i,
  // Far-side driver
  input  wire logic ext_en,
  input  wire logic ext_val
);
  logic last = 1'b0;

  // No pull on this pad: floating shows the inverse of the last driven level
  always @(pad_oe or pad_o or ext_en or ext_val) begin
    if (pad_oe || ext_en)
      last = pad_oe ? pad_o : ext_val;
  end

  assign pad_i = pad_oe ? pad_o : (ext_en ? ext_val : ~last);
endmodule : pad_model

// File: verif/test_gpio_io_logic_cell.sv
// Self-checking bench for the general-purpose I/O logic cell
`timescale 1ns/1ns
module test_gpio_io_logic_cell;
  import gpio_cell_pkg::*;
  logic       clk      = 1'b0;
  logic       nrst     = 1'b0;
  cell_mode_t mode     = MODE_IN;
  cell_cfg_t  cfg      = '0;
  logic [1:0] core_out = 2'h0;
  logic       core_oe  = 1'b0;
  logic       ext_en   = 1'b0;
  logic       ext_val  = 1'b0;
  logic [1:0] core_in;
  logic       alt_in;
  logic       pad_i;
  logic       pad_o;
  logic       pad_oe;
  int         errors = 0;
  int         samples_checked = 0;
  int         cycles = 0;

  // Capture and drive clocks share the core clock so edges stay predictable
  always #4 clk = ~clk;

  gpio_cell u_dut (.REF_CLK(clk), .NRST(nrst), .CAPTURE_REGISTER_CLOCK(clk),
    .DRIVE_REGISTER_CLOCK(clk), .MODE(mode), .CFG(cfg), .CORE_OUT(core_out),
    .CORE_OE(core_oe), .CORE_IN(core_in), .ALT_IN(alt_in), .PAD_I(pad_i),
    .PAD_O(pad_o), .PAD_OE(pad_oe));
  pad_model u_pad (.pad_o(pad_o), .pad_oe(pad_oe), .pad_i(pad_i), .ext_en(ext_en),
    .ext_val(ext_val));

  task automatic check(input string what, input logic [1:0] exp, input logic [1:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic step;
    @(posedge clk);
    #1;
  endtask : step

  task automatic fall;
    @(negedge clk);
    #1;
  endtask : fall

  // Configuration is static, so it only changes under reset
  task automatic setup(input cell_mode_t m, input cell_cfg_t c);
    nrst = 1'b0;
    mode = m;
    cfg  = c;
    step();
    step();
    nrst = 1'b1;
    step();
  endtask : setup

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic in_test(input logic neg);
    cell_cfg_t c = '0;
    c.in_reg = 1'b1;
    c.in_neg = neg;
    ext_en   = 1'b1;
    ext_val  = 1'b0;
    setup(MODE_IN, c);
    ext_val = 1'b1;
    fall();
    check("in half", {1'b0, neg}, {1'b0, core_in[0]});
    step();
    check("in reg", 2'h1, {1'b0, core_in[0]});
    check("in oe", 2'h0, {1'b0, pad_oe});
  endtask : in_test

  task automatic alt_test;
    cell_cfg_t c = '0;
    c.in_reg  = 1'b1;
    c.alt_sel = 1'b1;
    setup(MODE_IN, c);
    for (int i = 0; i < 2; i++) begin
      ext_val = ~ext_val;
      fall();
      check("alt", {1'b0, ext_val}, {1'b0, alt_in});
      step();
    end
  endtask : alt_test

  task automatic ddr_in_test(input logic rs);
    cell_cfg_t c = '0;
    c.in_reg    = 1'b1;
    c.in_ddr    = 1'b1;
    c.in_resync = rs;
    ext_val     = 1'b0;
    setup(MODE_IN, c);
    ext_val = 1'b1;
    fall();
    if (!rs)
      check("ddr in", 2'h2, core_in);
    else
      check("resync early", 2'h0, core_in);
    step();
    ext_val = 1'b0;
    fall();
    if (rs)
      check("resync in", 2'h3, core_in);
    else
      check("ddr in next", 2'h1, core_in);
  endtask : ddr_in_test

  task automatic out_test(input logic inv, input logic neg);
    cell_cfg_t c = '0;
    c.out_reg = 1'b1;
    c.out_neg = neg;
    c.out_inv = inv;
    core_out  = 2'h0;
    setup(MODE_OUT, c);
    for (int i = 1; i >= 0; i--) begin
      core_out = 2'(i);
      #1;
      check("out hold", {1'b0, ~i[0] ^ inv}, {1'b0, pad_o});
      if (neg)
        fall();
      else
        step();
      check("out reg", {1'b0, i[0] ^ inv}, {1'b0, pad_o});
      check("out oe", 2'h1, {1'b0, pad_oe});
      if (neg)
        step();
    end
  endtask : out_test

  // Unregistered drive must show before the next rising edge of the drive clock
  task automatic out_bypass_test;
    cell_cfg_t c = '0;
    c.out_inv = 1'b1;
    core_out  = 2'h0;
    setup(MODE_OUT, c);
    check("out bypass", 2'h1, {1'b0, pad_o});
    core_out = 2'h1;
    fall();
    check("out bypass", 2'h0, {1'b0, pad_o});
    step();
  endtask : out_bypass_test

  // Word changes after the rising edge, so only resync keeps the old high bit
  task automatic ddr_out_test(input logic rs);
    cell_cfg_t c = '0;
    c.out_reg    = 1'b1;
    c.out_ddr    = 1'b1;
    c.out_resync = rs;
    core_out     = 2'h0;
    setup(MODE_OUT, c);
    core_out = 2'h2;
    step();
    check("ddr out hi", 2'h0, {1'b0, pad_o});
    core_out = 2'h1;
    fall();
    check("ddr out lo", {1'b0, rs}, {1'b0, pad_o});
    step();
    check("ddr out next", 2'h1, {1'b0, pad_o});
  endtask : ddr_out_test

  task automatic bidir_test(input logic oreg, input logic oneg);
    cell_cfg_t c = '0;
    c.out_reg = 1'b1;
    c.oe_reg  = oreg;
    c.oe_neg  = oneg;
    core_out  = 2'h1;
    core_oe   = 1'b0;
    ext_en    = 1'b1;
    setup(MODE_BI, c);
    check("bi oe off", 2'h0, {1'b0, pad_oe});
    ext_val = ~ext_val;
    fall();
    check("bi in", {1'b0, ext_val}, {1'b0, core_in[0]});
    step();
    core_oe = 1'b1;
    ext_en  = 1'b0;
    fall();
    check("bi oe edge", {1'b0, !oreg || oneg}, {1'b0, pad_oe});
    step();
    check("bi oe on", 2'h1, {1'b0, pad_oe});
    check("bi out", 2'h1, {1'b0, pad_o});
    check("bi loop", 2'h1, {1'b0, core_in[0]});
  endtask : bidir_test

  task automatic clkout_test;
    setup(MODE_CK, '0);
    check("ck hi", 2'h1, {1'b0, pad_o});
    check("ck oe", 2'h1, {1'b0, pad_oe});
    fall();
    check("ck lo", 2'h0, {1'b0, pad_o});
  endtask : clkout_test

  task automatic final_report;
    if (errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      final_report();
    end
  end

  initial begin
    in_test(1'b0);
    in_test(1'b1);
    alt_test();
    ddr_in_test(1'b0);
    ddr_in_test(1'b1);
    out_test(1'b0, 1'b0);
    out_test(1'b1, 1'b1);
    out_bypass_test();
    ddr_out_test(1'b0);
    ddr_out_test(1'b1);
    bidir_test(1'b1, 1'b0);
    bidir_test(1'b0, 1'b0);
    bidir_test(1'b1, 1'b1);
    clkout_test();
    final_report();
  end
endmodule : test_gpio_io_logic_cell
